//--- pkg/aesc_pkg.sv
// Constants for the error severity and correctable status register pair.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package aesc_pkg;

  // ----------------------------------------
  // Bus
  // ----------------------------------------
  localparam int          AESC_ADDR_W    = 12;
  localparam logic [1:0]  AESC_RESP_OKAY = 2'h0;
  localparam logic [1:0]  AESC_RESP_SLV  = 2'h2;
  localparam logic [31:0] AESC_ZERO      = 32'h0000_0000;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] AESC_UES_ADDR  = 12'h10c;
  localparam logic [11:0] AESC_CES_ADDR  = 12'h110;

  // Severity: bits 0,4,5,12,13,16-20 writable; 14,15 and reserved read zero.
  localparam logic [31:0] AESC_UES_WMASK = 32'h001f_3031;
  // Severity reset: bits 4,5,13,17,18 set.
  localparam logic [31:0] AESC_UES_RESET = 32'h0006_2030;
  // Event positions that take part in classification (bit 0 excluded).
  localparam logic [31:0] AESC_UES_EVMSK = 32'h001f_3030;
  // Status: bits 0,6,7,8,12,13 implemented.
  localparam logic [31:0] AESC_CES_WMASK = 32'h0000_31c1;
  localparam logic [31:0] AESC_CES_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Correctable status bit positions
  // ----------------------------------------
  localparam int AESC_COR_RECEIVER = 0;
  localparam int AESC_COR_BAD_TLP  = 6;
  localparam int AESC_COR_BAD_LINK = 7;
  localparam int AESC_COR_ROLLOVER = 8;
  localparam int AESC_COR_REPLAYTO = 12;
  localparam int AESC_COR_ADVISORY = 13;

  // ----------------------------------------
  // Bus state machines
  // ----------------------------------------
  typedef enum logic {AESC_WR_IDLE, AESC_WR_RESP} aesc_wr_state_t;
  typedef enum logic {AESC_RD_IDLE, AESC_RD_RESP} aesc_rd_state_t;

endpackage

//--- design/aesc_regs.sv
// Uncorrectable error severity and correctable error status registers.
// Assumes events arrive as one-cycle pulses on CLK_I, and that the mask
// registers live elsewhere and are presented here as levels.
// Function
// RULE_01: Unmasked uncorrectable event with severity one reports fatal, else non-fatal.
// RULE_02: Severity applies only to events whose uncorrectable mask bit is clear.
// RULE_03: Severity bit 4, link protocol fault, read-write sticky, resets one.
// RULE_04: Severity bit 5, surprise link loss, read-write sticky, resets one.
// RULE_05: Severity bit 12, poisoned packet, read-write sticky, resets zero.
// RULE_06: Severity bit 13, flow credit protocol fault, read-write sticky, resets one.
// RULE_07: Severity bit 14, completion timeout, read-only zero.
// RULE_08: Severity bit 15, completer abort, read-only zero.
// RULE_09: Severity bit 16, unexpected completion, read-write sticky, resets zero.
// RULE_10: Severity bit 17, receive overflow, read-write sticky, resets one.
// RULE_11: Severity bit 18, bad format packet, read-write sticky, resets one.
// RULE_12: Severity bit 19, end-to-end CRC, read-write sticky, resets zero.
// RULE_13: Severity bit 20, unsupported request, read-write sticky, resets zero.
// RULE_14: Severity bit 0 is plain sticky storage, resets zero, no effect.
// RULE_15: Status bit 0 sets on a physical layer receiver fault.
// RULE_16: Status bit 6 sets on bad transaction packet, bit 7 on bad link packet.
// RULE_17: Status bit 8 sets when the replay count rolls over.
// RULE_18: Status bit 12 sets when the replay timer expires.
// RULE_19: Status bit 13 sets on an advisory non-fatal error.
// RULE_20: Masked uncorrectable event is neither logged nor reported.
// RULE_21: Masked correctable event is not reported.
// RULE_22: Status cleared by writing one; sticky bits survive all but power-on reset.
// RULE_23: Reserved bits read zero and ignore writes.

`timescale 1ns/10ps

module aesc_regs
  import aesc_pkg::*;
(
  input  wire logic                   CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic                   HOT_RST_N_I,
  input  wire logic                   S_AXI_AWVALID_I,
  output logic                        S_AXI_AWREADY_O,
  input  wire logic [AESC_ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic                   S_AXI_WVALID_I,
  output logic                        S_AXI_WREADY_O,
  input  wire logic [31:0]            S_AXI_WDATA_I,
  input  wire logic [3:0]             S_AXI_WSTRB_I,
  output logic                        S_AXI_BVALID_O,
  input  wire logic                   S_AXI_BREADY_I,
  output logic [1:0]                  S_AXI_BRESP_O,
  input  wire logic                   S_AXI_ARVALID_I,
  output logic                        S_AXI_ARREADY_O,
  input  wire logic [AESC_ADDR_W-1:0] S_AXI_ARADDR_I,
  output logic                        S_AXI_RVALID_O,
  input  wire logic                   S_AXI_RREADY_I,
  output logic [31:0]                 S_AXI_RDATA_O,
  output logic [1:0]                  S_AXI_RRESP_O,
  input  wire logic [31:0]            UNC_EVENT_I,
  input  wire logic [31:0]            UNCORRECTABLE_ERROR_MASK_I,
  input  wire logic [31:0]            CORRECTABLE_ERROR_MASK_I,
  input  wire logic                   RECEIVER_FAULT_I,
  input  wire logic                   BAD_TRANSACTION_PACKET_I,
  input  wire logic                   BAD_LINK_PACKET_I,
  input  wire logic                   REPLAY_COUNT_ROLLOVER_I,
  input  wire logic                   REPLAY_TIMER_EXPIRY_I,
  input  wire logic                   ADVISORY_NONFATAL_I,
  output logic                        FATAL_REPORT_O,
  output logic                        NONFATAL_REPORT_O,
  output logic [31:0]                 UNC_LOG_O,
  output logic                        COR_REPORT_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic hits(input logic [AESC_ADDR_W-1:0] a,
                                input logic [11:0] r);
    return a[AESC_ADDR_W-1:2] == r[AESC_ADDR_W-1:2];
  endfunction

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  aesc_wr_state_t         wr_state;
  aesc_wr_state_t         next_wr_state;
  logic                   aw_got;
  logic                   next_aw_got;
  logic                   w_got;
  logic                   next_w_got;
  logic [AESC_ADDR_W-1:0] aw_addr;
  logic [AESC_ADDR_W-1:0] next_aw_addr;
  logic [31:0]            w_data;
  logic [31:0]            next_w_data;
  logic [3:0]             w_strb;
  logic [3:0]             next_w_strb;
  logic [1:0]             bresp;
  logic [1:0]             next_bresp;
  logic                   wr_fire;
  logic [AESC_ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_bits;
  logic [31:0]            wr_bmask;

  assign S_AXI_AWREADY_O = (wr_state == AESC_WR_IDLE) && !aw_got;
  assign S_AXI_WREADY_O  = (wr_state == AESC_WR_IDLE) && !w_got;
  assign S_AXI_BVALID_O  = (wr_state == AESC_WR_RESP);
  assign S_AXI_BRESP_O   = bresp;

  always_comb begin
    logic aw_fire;
    logic w_fire;
    logic [31:0] wd;
    logic [3:0] ws;
    aw_fire       = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    w_fire        = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wd            = w_fire ? S_AXI_WDATA_I : w_data;
    ws            = w_fire ? S_AXI_WSTRB_I : w_strb;
    wr_addr       = aw_fire ? S_AXI_AWADDR_I : aw_addr;
    wr_bmask      = strb_mask(ws);
    wr_bits       = wd & wr_bmask;
    wr_fire       = 1'b0;
    next_wr_state = wr_state;
    next_aw_got   = aw_got || aw_fire;
    next_w_got    = w_got || w_fire;
    next_aw_addr  = aw_fire ? S_AXI_AWADDR_I : aw_addr;
    next_w_data   = wd;
    next_w_strb   = ws;
    next_bresp    = bresp;
    case (wr_state)
      AESC_WR_IDLE: begin
        if (next_aw_got && next_w_got) begin
          wr_fire       = 1'b1;
          next_aw_got   = 1'b0;
          next_w_got    = 1'b0;
          next_wr_state = AESC_WR_RESP;
          next_bresp    = (hits(wr_addr, AESC_UES_ADDR) || hits(wr_addr, AESC_CES_ADDR))
                          ? AESC_RESP_OKAY : AESC_RESP_SLV;
        end
      end
      AESC_WR_RESP: begin
        if (S_AXI_BREADY_I) begin
          next_wr_state = AESC_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = AESC_WR_IDLE;
      end
    endcase
    if (!HOT_RST_N_I) begin
      wr_fire       = 1'b0;
      next_wr_state = AESC_WR_IDLE;
      next_aw_got   = 1'b0;
      next_w_got    = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_state <= AESC_WR_IDLE;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      aw_addr  <= '0;
      w_data   <= AESC_ZERO;
      w_strb   <= '0;
      bresp    <= AESC_RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      aw_got   <= next_aw_got;
      w_got    <= next_w_got;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bresp    <= next_bresp;
    end
  end

  // ----------------------------------------
  // Sticky registers
  // ----------------------------------------
  // Only the power-on reset touches these; the hot reset leaves them alone.
  logic [31:0] sev;
  logic [31:0] next_sev;
  logic [31:0] ces;
  logic [31:0] next_ces;
  logic [31:0] cor_set;
  logic [31:0] ces_clr;

  always_comb begin
    cor_set = AESC_ZERO;
    cor_set[AESC_COR_RECEIVER] = RECEIVER_FAULT_I;          // see RULE_15
    cor_set[AESC_COR_BAD_TLP]  = BAD_TRANSACTION_PACKET_I;  // see RULE_16
    cor_set[AESC_COR_BAD_LINK] = BAD_LINK_PACKET_I;         // see RULE_16
    cor_set[AESC_COR_ROLLOVER] = REPLAY_COUNT_ROLLOVER_I;   // see RULE_17
    cor_set[AESC_COR_REPLAYTO] = REPLAY_TIMER_EXPIRY_I;     // see RULE_18
    cor_set[AESC_COR_ADVISORY] = ADVISORY_NONFATAL_I;       // see RULE_19
    ces_clr  = (wr_fire && hits(wr_addr, AESC_CES_ADDR)) ? wr_bits : AESC_ZERO;
    // A set arriving with its clear wins.
    next_ces = ((ces & ~ces_clr) | cor_set) & AESC_CES_WMASK;  // see RULE_22
    next_sev = sev;
    if (wr_fire && hits(wr_addr, AESC_UES_ADDR)) begin
      // Only enabled bytes of implemented bits change; 14, 15 and reserved stay zero.
      next_sev = (sev & ~(wr_bmask & AESC_UES_WMASK))
                 | (wr_bits & AESC_UES_WMASK);  // see RULE_07 see RULE_08 see RULE_23
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin  // see RULE_09 see RULE_10 see RULE_11 see RULE_12
      sev <= AESC_UES_RESET;  // see RULE_03 see RULE_04 see RULE_05 see RULE_06
      ces <= AESC_CES_RESET;  // see RULE_22
    end else begin
      sev <= next_sev;        // see RULE_13 see RULE_14
      ces <= next_ces;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  aesc_rd_state_t rd_state;
  aesc_rd_state_t next_rd_state;
  logic [31:0]    rdata;
  logic [31:0]    next_rdata;
  logic [1:0]     rresp;
  logic [1:0]     next_rresp;
  logic           ar_fire;

  assign S_AXI_ARREADY_O = (rd_state == AESC_RD_IDLE);
  assign S_AXI_RVALID_O  = (rd_state == AESC_RD_RESP);
  assign S_AXI_RDATA_O   = rdata;
  assign S_AXI_RRESP_O   = rresp;
  assign ar_fire         = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      AESC_RD_IDLE: begin
        if (ar_fire) begin
          next_rd_state = AESC_RD_RESP;
          next_rresp    = AESC_RESP_OKAY;
          if (hits(S_AXI_ARADDR_I, AESC_UES_ADDR)) begin
            next_rdata = sev & AESC_UES_WMASK;  // see RULE_23
          end else if (hits(S_AXI_ARADDR_I, AESC_CES_ADDR)) begin
            next_rdata = ces & AESC_CES_WMASK;
          end else begin
            next_rdata = AESC_ZERO;
            next_rresp = AESC_RESP_SLV;
          end
        end
      end
      AESC_RD_RESP: begin
        if (S_AXI_RREADY_I) begin
          next_rd_state = AESC_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = AESC_RD_IDLE;
      end
    endcase
    if (!HOT_RST_N_I) begin
      next_rd_state = AESC_RD_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_state <= AESC_RD_IDLE;
      rdata    <= AESC_ZERO;
      rresp    <= AESC_RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  // ----------------------------------------
  // Error classification and reporting
  // ----------------------------------------
  logic [31:0] unc_live;
  logic        next_fatal;
  logic        next_nonfatal;
  logic [31:0] next_log;
  logic        next_cor;

  always_comb begin
    unc_live      = UNC_EVENT_I & ~UNCORRECTABLE_ERROR_MASK_I & AESC_UES_EVMSK;  // see RULE_02
    next_fatal    = |(unc_live & sev);        // see RULE_01
    next_nonfatal = |(unc_live & ~sev);       // see RULE_01
    next_log      = unc_live;                 // see RULE_20
    next_cor      = |(cor_set & ~CORRECTABLE_ERROR_MASK_I);  // see RULE_21
    if (!HOT_RST_N_I) begin
      next_fatal    = 1'b0;
      next_nonfatal = 1'b0;
      next_log      = AESC_ZERO;
      next_cor      = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FATAL_REPORT_O    <= 1'b0;
      NONFATAL_REPORT_O <= 1'b0;
      UNC_LOG_O         <= AESC_ZERO;
      COR_REPORT_O      <= 1'b0;
    end else begin
      FATAL_REPORT_O    <= next_fatal;
      NONFATAL_REPORT_O <= next_nonfatal;
      UNC_LOG_O         <= next_log;
      COR_REPORT_O      <= next_cor;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I || !HOT_RST_N_I);

  sequence s_fatal_cause;
    |(UNC_EVENT_I & ~UNCORRECTABLE_ERROR_MASK_I & AESC_UES_EVMSK & sev);
  endsequence

  sequence s_nonfatal_cause;
    |(UNC_EVENT_I & ~UNCORRECTABLE_ERROR_MASK_I & AESC_UES_EVMSK & ~sev);
  endsequence

  sequence s_write_taken;
    wr_fire && hits(wr_addr, AESC_UES_ADDR);
  endsequence

  AST_FATAL_CLASS: assert property (s_fatal_cause |=> FATAL_REPORT_O)  // see RULE_01
    else $error("Unmasked severe event not reported as fatal.");

  AST_NONFATAL_CLASS: assert property (  // see RULE_01
    s_nonfatal_cause |=> NONFATAL_REPORT_O)
    else $error("Unmasked event of low severity not reported as non-fatal.");

  AST_MASKED_SILENT: assert property (  // see RULE_20
    !(|(UNC_EVENT_I & ~UNCORRECTABLE_ERROR_MASK_I))
    |=> !FATAL_REPORT_O && !NONFATAL_REPORT_O && UNC_LOG_O == AESC_ZERO)
    else $error("Masked uncorrectable event was reported or logged.");

  AST_SEV_RESERVED: assert property (  // see RULE_23
    s_write_taken |=> (sev & ~AESC_UES_WMASK) == AESC_ZERO)
    else $error("Severity reserved or read-only bit became set.");

  AST_RX_FAULT_SET: assert property (  // see RULE_15
    RECEIVER_FAULT_I |=> ces[AESC_COR_RECEIVER] ##1 ces[AESC_COR_RECEIVER] || $past(ces_clr[0]))
    else $error("Receiver fault did not set its status bit.");

  AST_SET_WINS: assert property (  // see RULE_22
    (REPLAY_TIMER_EXPIRY_I && ces_clr[AESC_COR_REPLAYTO]) |=> ces[AESC_COR_REPLAYTO])
    else $error("Clear in the same cycle lost a replay timer event.");

  AST_W1C_CLEAR: assert property (  // see RULE_22
    (ces_clr[AESC_COR_BAD_TLP] && !BAD_TRANSACTION_PACKET_I) |=> !ces[AESC_COR_BAD_TLP])
    else $error("Write of one did not clear bad packet status.");

  AST_COR_MASKED: assert property (  // see RULE_21
    !(|(cor_set & ~CORRECTABLE_ERROR_MASK_I)) |=> !COR_REPORT_O)
    else $error("Masked correctable event was reported.");

  AST_READ_ANSWER: assert property (  // see RULE_23
    ar_fire && hits(S_AXI_ARADDR_I, AESC_UES_ADDR)
    |=> S_AXI_RVALID_O && (S_AXI_RDATA_O & ~AESC_UES_WMASK) == AESC_ZERO)
    else $error("Severity read not answered next cycle with clean reserved bits.");

  AST_LOG_UNMASKED: assert property (  // see RULE_20
    1'b1 |=> (UNC_LOG_O & $past(UNCORRECTABLE_ERROR_MASK_I)) == AESC_ZERO)
    else $error("Masked uncorrectable event appeared in the log.");

endmodule

//--- sim/aesc_host.sv
// AXI4-Lite master model standing in for configuration software.
// Assumes one caller process and one transfer at a time.

`timescale 1ns/10ps

module aesc_host
  import aesc_pkg::*;
(
  input  wire logic                   clk_i,
  output logic                        awvalid_o,
  input  wire logic                   awready_i,
  output logic [AESC_ADDR_W-1:0]      awaddr_o,
  output logic                        wvalid_o,
  input  wire logic                   wready_i,
  output logic [31:0]                 wdata_o,
  output logic [3:0]                  wstrb_o,
  input  wire logic                   bvalid_i,
  output logic                        bready_o,
  input  wire logic [1:0]             bresp_i,
  output logic                        arvalid_o,
  input  wire logic                   arready_i,
  output logic [AESC_ADDR_W-1:0]      araddr_o,
  input  wire logic                   rvalid_i,
  output logic                        rready_o,
  input  wire logic [31:0]            rdata_i,
  input  wire logic [1:0]             rresp_i
);

  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
  end

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // Released address and data lines show the inverse so stale values are never trusted.
  task automatic wr(input logic [AESC_ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk_i);
    awaddr_o  <= a;
    wdata_o   <= d;
    wstrb_o   <= s;
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk_i);
      if (!ad && awready_i) begin
        ad = 1'b1;
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
      end
      if (!dd && wready_i) begin
        dd = 1'b1;
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
    end
    @(posedge clk_i);
    while (!bvalid_i) @(posedge clk_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [AESC_ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    @(posedge clk_i);
    while (!arready_i) @(posedge clk_i);
    arvalid_o <= 1'b0;
    araddr_o  <= ~a;
    @(posedge clk_i);
    while (!rvalid_i) @(posedge clk_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask

endmodule

//--- sim/aesc_regs_bench.sv
// Self-checking bench for the severity and correctable status registers.
// Assumes aesc_host drives the bus; a model here predicts every result.

`timescale 1ns/10ps

module aesc_regs_bench
  import aesc_pkg::*;
;

  localparam logic [31:0] SEV_RST = 32'h0006_2030;
  localparam logic [31:0] SEV_RW  = 32'h001f_3031;
  localparam logic [31:0] SEV_EV  = 32'h001f_3030;
  localparam logic [31:0] CES_RW  = 32'h0000_31c1;

  logic              clk = 1'b0;
  logic              rst_n, hot_n, fatal, nonfat, cor;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [11:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata, ev, um, cm, ulog, sev_m, ces_m, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  logic [5:0]        cev;
  int                bad_count, comparisons;

  always #25 clk = ~clk;

  aesc_regs dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .HOT_RST_N_I(hot_n),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .UNC_EVENT_I(ev),
    .UNCORRECTABLE_ERROR_MASK_I(um), .CORRECTABLE_ERROR_MASK_I(cm),
    .RECEIVER_FAULT_I(cev[0]), .BAD_TRANSACTION_PACKET_I(cev[1]),
    .BAD_LINK_PACKET_I(cev[2]), .REPLAY_COUNT_ROLLOVER_I(cev[3]),
    .REPLAY_TIMER_EXPIRY_I(cev[4]), .ADVISORY_NONFATAL_I(cev[5]),
    .FATAL_REPORT_O(fatal), .NONFATAL_REPORT_O(nonfat), .UNC_LOG_O(ulog),
    .COR_REPORT_O(cor)
  );

  aesc_host host_u (
    .clk_i(clk), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr),
    .wvalid_o(wvalid), .wready_i(wready), .wdata_o(wdata), .wstrb_o(wstrb),
    .bvalid_i(bvalid), .bready_o(bready), .bresp_i(bresp), .arvalid_o(arvalid),
    .arready_i(arready), .araddr_o(araddr), .rvalid_i(rvalid), .rready_o(rready),
    .rdata_i(rdata), .rresp_i(rresp)
  );

  // ----------------------------------------
  // Comparison and model
  // ----------------------------------------
  function automatic logic [31:0] bmask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  task automatic fail(input logic [34:0] g, input logic [34:0] e);
    bad_count++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) fail({3'h0, g}, {3'h0, e});
  endtask

  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) fail({33'h0, g}, {33'h0, e});
  endtask

  task automatic cmp_rep(input logic [34:0] g, input logic [34:0] e);
    comparisons++;
    if (g !== e) fail(g, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    host_u.rd(a, d, r);
    cmp_word(d, e);
    cmp_resp(r, er);
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                        input logic [1:0] er);
    host_u.wr(a, v, s, r);
    cmp_resp(r, er);
    if (a == AESC_UES_ADDR) sev_m = (sev_m & ~bmask(s)) | (v & bmask(s) & SEV_RW);
    if (a == AESC_CES_ADDR) ces_m = ces_m & ~(v & bmask(s) & CES_RW);
  endtask

  // Drives one cycle of events with the given masks and checks the reports.
  task automatic pulse(input logic [31:0] e, input logic [5:0] c, input logic [31:0] u,
                       input logic [31:0] k);
    logic [31:0] lg;
    logic [31:0] cs;
    lg = e & ~u & SEV_EV;
    cs = {18'h0, c[5], c[4], 3'h0, c[3], c[2], c[1], 5'h0, c[0]};
    @(posedge clk);
    ev  <= e;
    cev <= c;
    um  <= u;
    cm  <= k;
    @(posedge clk);
    ev  <= '0;
    cev <= '0;
    ces_m = ces_m | cs;
    #1;
    cmp_rep({fatal, nonfat, cor, ulog}, {|(lg & sev_m), |(lg & ~sev_m), |(cs & ~k), lg});
  endtask

  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(96));
    bad_count = 0;
    comparisons = 0;
    {rst_n, ev, cev, um, cm} = '0;
    hot_n = 1'b1;
    sev_m = SEV_RST;
    ces_m = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(AESC_UES_ADDR, sev_m, 2'h0);
    rd_chk(AESC_CES_ADDR, ces_m, 2'h0);
    wr_chk(AESC_UES_ADDR, 32'hffff_ffff, 4'hf, 2'h0);
    rd_chk(AESC_UES_ADDR, sev_m, 2'h0);
    wr_chk(12'h114, 32'hffff_ffff, 4'hf, 2'h2);
    rd_chk(12'h000, 32'h0, 2'h2);
    rd_chk(AESC_UES_ADDR, sev_m, 2'h0);
    for (int i = 0; i < 48; i++) begin
      pulse($urandom & $urandom & $urandom, 6'($urandom & $urandom),
            $urandom & $urandom, $urandom & $urandom);
      if (i % 4 == 3) begin
        rd_chk(AESC_CES_ADDR, ces_m, 2'h0);
        wr_chk(AESC_CES_ADDR, $urandom, 4'($urandom), 2'h0);
        rd_chk(AESC_CES_ADDR, ces_m, 2'h0);
        wr_chk(AESC_UES_ADDR, $urandom, 4'($urandom), 2'h0);
        rd_chk(AESC_UES_ADDR, sev_m, 2'h0);
      end
    end
    // A replay timer event in the very cycle of a clear-all write must survive.
    fork
      wr_chk(AESC_CES_ADDR, 32'hffff_ffff, 4'hf, 2'h0);
      pulse(32'h0, 6'h10, 32'h0, 32'h0);
    join
    ces_m = ces_m | 32'h0000_1000;
    rd_chk(AESC_CES_ADDR, ces_m, 2'h0);
    wr_chk(AESC_UES_ADDR, 32'h0010_1001, 4'hf, 2'h0);
    pulse(32'h0010_0010, 6'h3f, 32'h0, 32'hffff_ffff);
    @(posedge clk);
    hot_n <= 1'b0;
    @(posedge clk);
    hot_n <= 1'b1;
    rd_chk(AESC_UES_ADDR, sev_m, 2'h0);
    rd_chk(AESC_CES_ADDR, ces_m, 2'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sev_m = SEV_RST;
    ces_m = '0;
    rd_chk(AESC_UES_ADDR, sev_m, 2'h0);
    rd_chk(AESC_CES_ADDR, ces_m, 2'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

endmodule
